// ---- rtl/fcc_map.vh ----
/*
 * Constants for the flash command controller: bus cycle timing, command
 * codes, unlock addresses, status bit positions and user-side opcodes.
 * Assumes a 125 MHz controller clock (8 ns period).
 */
`ifndef FCC_MAP_VH
`define FCC_MAP_VH

// Clock period in ns
`define FCC_CLK_NS 8
// Bus strobe low time in ns, rounded up to whole cycles
`define FCC_STROBE_NS 100
`define FCC_STROBE_CYC ((`FCC_STROBE_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS)
// Bus idle time between strobes in ns
`define FCC_IDLE_NS 40
`define FCC_IDLE_CYC ((`FCC_IDLE_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS)
// Hardware reset pulse width in ns
`define FCC_RST_NS 500
`define FCC_RST_CYC ((`FCC_RST_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS)

// Unlock cycle addresses (word mode) and data
`define FCC_UNLOCK_A1 20'h00555
`define FCC_UNLOCK_A2 20'h002aa
`define FCC_UNLOCK_D1 16'h00aa
`define FCC_UNLOCK_D2 16'h0055
// Command codes
`define FCC_CMD_PROG 16'h00a0
`define FCC_CMD_ERASE 16'h0080
`define FCC_CMD_CHIP 16'h0010
`define FCC_CMD_SECT 16'h0030
`define FCC_CMD_BYPASS 16'h0020
`define FCC_CMD_BYP_EXIT1 16'h0090
`define FCC_CMD_BYP_EXIT2 16'h0000
`define FCC_CMD_SUSPEND 16'h00b0
`define FCC_CMD_RESUME 16'h0030
`define FCC_CMD_RESET 16'h00f0

// Status bit positions on the data lines
`define FCC_POLL_BIT 7
`define FCC_ALT_BIT 6

// Opcodes on the user side
`define FCC_OP_READ 3'h0
`define FCC_OP_PROG 3'h1
`define FCC_OP_CHIP 3'h2
`define FCC_OP_SECT 3'h3
`define FCC_OP_SUSP 3'h4
`define FCC_OP_RESUME 3'h5
`define FCC_OP_BYP_ON 3'h6
`define FCC_OP_BYP_OFF 3'h7

`endif

// ---- rtl/fcc_bus_cycle.v ----
/*
 * One bus cycle on the flash pins: drives address, strobes and data for a
 * read or a write and returns read data.
 * Assumes data_lines input is already synchronised by the caller.
 */
`timescale 1ns/1ns
`include "fcc_map.vh"

module fcc_bus_cycle #(
	parameter ADDR_W = 20
) (
	input wire clock_in,
	input wire reset_n_in,
	input wire start_in,
	input wire write_in,
	input wire [ADDR_W-1:0] addr_in,
	input wire [15:0] wdata_in,
	input wire [15:0] pin_data_in,
	output reg busy_out,
	output reg done_out,
	output reg [15:0] rdata_out,
	output reg [ADDR_W-1:0] pin_addr_out,
	output reg [15:0] pin_data_out,
	output reg pin_data_oe_n_out,
	output reg chip_sel_n_out,
	output reg write_n_out,
	output reg read_n_out
);

localparam ST_IDLE = 3'b001;
localparam ST_STROBE = 3'b010;
localparam ST_GAP = 3'b100;

reg [2:0] state;
reg [7:0] count;
reg is_write;

////////////////////////////////////////////////////////////////////////
// Strobe low for a fixed time, then an idle gap so no two drivers meet
always @(posedge clock_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		state <= ST_IDLE;
		count <= 8'h00;
		is_write <= 1'b0;
		busy_out <= 1'b0;
		done_out <= 1'b0;
		rdata_out <= 16'h0000;
		pin_addr_out <= {ADDR_W{1'b0}};
		pin_data_out <= 16'h0000;
		pin_data_oe_n_out <= 1'b1;
		chip_sel_n_out <= 1'b1;
		write_n_out <= 1'b1;
		read_n_out <= 1'b1;
	end else begin
		done_out <= 1'b0;
		case (state)
		ST_IDLE: begin
			if (start_in) begin
				busy_out <= 1'b1;
				is_write <= write_in;
				pin_addr_out <= addr_in;
				pin_data_out <= wdata_in;
				pin_data_oe_n_out <= ~write_in; // R03
				chip_sel_n_out <= 1'b0;
				write_n_out <= ~write_in; // R04
				read_n_out <= write_in; // R03
				count <= 8'h00;
				state <= ST_STROBE;
			end
		end
		ST_STROBE: begin
			count <= count + 8'h01;
			if (count == (`FCC_STROBE_CYC - 1)) begin
				if (!is_write)
					rdata_out <= pin_data_in;
				chip_sel_n_out <= 1'b1;
				write_n_out <= 1'b1;
				read_n_out <= 1'b1;
				count <= 8'h00;
				state <= ST_GAP;
			end
		end
		ST_GAP: begin
			// Data held one gap past the write strobe rise for hold time
			count <= count + 8'h01;
			if (count == (`FCC_IDLE_CYC - 1)) begin
				pin_data_oe_n_out <= 1'b1; // R03
				busy_out <= 1'b0;
				done_out <= 1'b1;
				state <= ST_IDLE;
			end
		end
		default: state <= ST_IDLE;
		endcase
	end
end

endmodule

// ---- rtl/fcc_controller.v ----
/*
 * Host-side controller for a parallel flash: takes user operations, issues
 * the flash command sequences over the pins and polls completion.
 * Assumes one flash on the pins; the data bus wire is resolved outside.
 *
// How it works
// R01: Device array is byte- or word-addressed by the width select.
// R02: Word width uses sixteen data lines; byte width uses the low eight.
// R03: Chip select, write and read strobes are active low; no bus contention.
// R04: Commands are plain write cycles into the device command register.
// R05: Device latches address and data of each command write.
// R06: A program sequence starts a self-timed program inside the device.
// R07: Bypass mode programs with two writes instead of four.
// R08: An erase sequence starts the self-timed erase inside the device.
// R09: Erase covers the whole chip or chosen sectors.
// R10: Completion shows on the done pin, poll bit and alternating bit.
// R11: After completion the device serves reads and takes new commands.
// R12: Erasing one sector leaves the others intact.
// R13: Device rejects writes during low supply.
// R14: Protected sectors refuse program and erase.
// R15: Erase may be suspended indefinitely, then resumed.
// R16: Hardware reset aborts operations and returns to array read.
// R17: Device sleeps itself when addresses stay stable.
// R18: Host may put the device in standby by its controls.
// R19: Byte-mode sector map: boot sectors plus fifteen 64 KB sectors.
// R20: During an operation reads of the affected area return status.
 */
`timescale 1ns/1ns
`include "fcc_map.vh"

module fcc_controller #(
	parameter ADDR_W = 20
) (
	input wire clock_in,
	input wire reset_n_in,
	input wire op_valid_in,
	input wire [2:0] op_code_in,
	input wire [ADDR_W-1:0] op_addr_in,
	input wire [15:0] op_data_in,
	input wire byte_mode_in,
	input wire [15:0] data_lines_in,
	input wire operation_done_pin_in,
	output reg op_ready_out,
	output reg op_done_out,
	output reg op_error_out,
	output reg [15:0] rd_data_out,
	output reg [ADDR_W-1:0] flash_addr_out,
	output reg [15:0] data_lines_out,
	output reg data_lines_oe_n_out,
	output reg chip_sel_n_out,
	output reg write_n_out,
	output reg read_n_out,
	output reg byte_n_out,
	output reg flash_reset_n_out
);

localparam ST_RESET = 6'b000001;
localparam ST_IDLE = 6'b000010;
localparam ST_SEQ = 6'b000100;
localparam ST_WAIT = 6'b001000;
localparam ST_POLL = 6'b010000;
localparam ST_FINISH = 6'b100000;

reg [5:0] state;
reg [7:0] rst_count;
reg [2:0] op;
reg [2:0] step;
reg [2:0] last_step;
reg bypass;
reg pend;
reg [ADDR_W-1:0] op_addr;
reg [15:0] op_data;
reg have_prev;
reg [15:0] prev_read;
reg [15:0] din_meta;
reg [15:0] din_sync;
reg rb_meta;
reg rb_sync;
reg cyc_start;
reg cyc_write;
reg [ADDR_W-1:0] cyc_addr;
reg [15:0] cyc_wdata;
wire cyc_busy;
wire cyc_done;
wire [15:0] cyc_rdata;
wire [ADDR_W-1:0] pin_addr;
wire [15:0] pin_data;
wire pin_oe_n;
wire pin_cs_n;
wire pin_we_n;
wire pin_oe_rd_n;
reg [15:0] next_wdata;
reg [ADDR_W-1:0] next_addr;

////////////////////////////////////////////////////////////////////////
// Two-stage synchronisers for the data lines and the done pin
always @(posedge clock_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		din_meta <= 16'h0000;
		din_sync <= 16'h0000;
		rb_meta <= 1'b0;
		rb_sync <= 1'b0;
	end else begin
		din_meta <= data_lines_in;
		din_sync <= din_meta;
		rb_meta <= operation_done_pin_in;
		rb_sync <= rb_meta;
	end
end

fcc_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
	.clock_in(clock_in),
	.reset_n_in(reset_n_in),
	.start_in(cyc_start),
	.write_in(cyc_write),
	.addr_in(cyc_addr),
	.wdata_in(cyc_wdata),
	.pin_data_in(din_sync),
	.busy_out(cyc_busy),
	.done_out(cyc_done),
	.rdata_out(cyc_rdata),
	.pin_addr_out(pin_addr),
	.pin_data_out(pin_data),
	.pin_data_oe_n_out(pin_oe_n),
	.chip_sel_n_out(pin_cs_n),
	.write_n_out(pin_we_n),
	.read_n_out(pin_oe_rd_n)
);

////////////////////////////////////////////////////////////////////////
// Pins come from flops; chip select high between cycles gives standby
always @(posedge clock_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		flash_addr_out <= {ADDR_W{1'b0}};
		data_lines_out <= 16'h0000;
		data_lines_oe_n_out <= 1'b1;
		chip_sel_n_out <= 1'b1;
		write_n_out <= 1'b1;
		read_n_out <= 1'b1;
	end else begin
		flash_addr_out <= pin_addr;
		// Byte width drives the upper lines low
		data_lines_out <= byte_mode_in ? {8'h00, pin_data[7:0]} : pin_data; // R02
		data_lines_oe_n_out <= pin_oe_n; // R03
		chip_sel_n_out <= pin_cs_n; // R18
		write_n_out <= pin_we_n;
		read_n_out <= pin_oe_rd_n;
	end
end

////////////////////////////////////////////////////////////////////////
// Command sequence table: address and data of each step per operation
always @* begin
	next_addr = op_addr;
	next_wdata = op_data;
	last_step = 3'd0;
	case (op)
	`FCC_OP_PROG: begin
		if (bypass) begin
			// Bypass: command then data, two writes
			last_step = 3'd1; // R07
			if (step == 3'd0)
				next_wdata = `FCC_CMD_PROG;
		end else begin
			last_step = 3'd3; // R06
			case (step)
			3'd0: begin next_addr = `FCC_UNLOCK_A1; next_wdata = `FCC_UNLOCK_D1; end
			3'd1: begin next_addr = `FCC_UNLOCK_A2; next_wdata = `FCC_UNLOCK_D2; end
			3'd2: begin next_addr = `FCC_UNLOCK_A1; next_wdata = `FCC_CMD_PROG; end
			default: next_addr = op_addr; // R05
			endcase
		end
	end
	`FCC_OP_CHIP, `FCC_OP_SECT: begin
		last_step = 3'd5; // R08
		case (step)
		3'd0, 3'd3: begin next_addr = `FCC_UNLOCK_A1; next_wdata = `FCC_UNLOCK_D1; end
		3'd1, 3'd4: begin next_addr = `FCC_UNLOCK_A2; next_wdata = `FCC_UNLOCK_D2; end
		3'd2: begin next_addr = `FCC_UNLOCK_A1; next_wdata = `FCC_CMD_ERASE; end
		default: begin
			// Sector erase names the sector by its address
			if (op == `FCC_OP_CHIP) begin
				next_addr = `FCC_UNLOCK_A1;
				next_wdata = `FCC_CMD_CHIP; // R09
			end else
				next_wdata = `FCC_CMD_SECT; // R09
		end
		endcase
	end
	`FCC_OP_SUSP: next_wdata = `FCC_CMD_SUSPEND; // R15
	`FCC_OP_RESUME: next_wdata = `FCC_CMD_RESUME; // R15
	`FCC_OP_BYP_ON: begin
		last_step = 3'd2;
		case (step)
		3'd0: begin next_addr = `FCC_UNLOCK_A1; next_wdata = `FCC_UNLOCK_D1; end
		3'd1: begin next_addr = `FCC_UNLOCK_A2; next_wdata = `FCC_UNLOCK_D2; end
		default: begin next_addr = `FCC_UNLOCK_A1; next_wdata = `FCC_CMD_BYPASS; end
		endcase
	end
	`FCC_OP_BYP_OFF: begin
		last_step = 3'd1;
		next_wdata = (step == 3'd0) ? `FCC_CMD_BYP_EXIT1 : `FCC_CMD_BYP_EXIT2;
	end
	default: last_step = 3'd0;
	endcase
	// Byte width doubles unlock addresses, as in a real part, unless one equals the target address, which is kept as given
	if (byte_mode_in && next_addr != op_addr)
		next_addr = {next_addr[ADDR_W-2:0], 1'b0}; // R01
end

////////////////////////////////////////////////////////////////////////
// Main sequencer
always @(posedge clock_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		state <= ST_RESET;
		rst_count <= 8'h00;
		op <= `FCC_OP_READ;
		step <= 3'd0;
		bypass <= 1'b0;
		pend <= 1'b0;
		op_addr <= {ADDR_W{1'b0}};
		op_data <= 16'h0000;
		have_prev <= 1'b0;
		prev_read <= 16'h0000;
		cyc_start <= 1'b0;
		cyc_write <= 1'b0;
		cyc_addr <= {ADDR_W{1'b0}};
		cyc_wdata <= 16'h0000;
		op_ready_out <= 1'b0;
		op_done_out <= 1'b0;
		op_error_out <= 1'b0;
		rd_data_out <= 16'h0000;
		byte_n_out <= 1'b1;
		flash_reset_n_out <= 1'b0;
	end else begin
		cyc_start <= 1'b0;
		op_done_out <= 1'b0;
		byte_n_out <= ~byte_mode_in; // R01
		case (state)
		ST_RESET: begin
			// Pulse the device reset to abort anything and return to reads
			flash_reset_n_out <= 1'b0; // R16
			bypass <= 1'b0;
			rst_count <= rst_count + 8'h01;
			if (rst_count == (`FCC_RST_CYC - 1)) begin
				flash_reset_n_out <= 1'b1;
				op_ready_out <= 1'b1;
				state <= ST_IDLE;
			end
		end
		ST_IDLE: begin
			if (op_valid_in) begin
				op_ready_out <= 1'b0;
				op <= op_code_in;
				op_addr <= op_addr_in;
				op_data <= op_data_in;
				step <= 3'd0;
				have_prev <= 1'b0;
				op_error_out <= 1'b0;
				pend <= 1'b1;
				state <= ST_SEQ;
			end
		end
		ST_SEQ: begin
			if (pend && !cyc_busy && !cyc_start) begin
				pend <= 1'b0;
				cyc_start <= 1'b1;
				cyc_write <= (op != `FCC_OP_READ); // R04
				cyc_addr <= next_addr;
				cyc_wdata <= next_wdata;
			end else if (cyc_done) begin
				if (step != last_step) begin
					step <= step + 3'd1;
					pend <= 1'b1;
				end else if (op == `FCC_OP_READ) begin
					rd_data_out <= byte_mode_in ? {8'h00, cyc_rdata[7:0]} : cyc_rdata;
					state <= ST_FINISH;
				end else begin
					if (op == `FCC_OP_BYP_ON)
						bypass <= 1'b1; // R07
					if (op == `FCC_OP_BYP_OFF)
						bypass <= 1'b0;
					if (op == `FCC_OP_PROG || op == `FCC_OP_CHIP ||
						op == `FCC_OP_SECT || op == `FCC_OP_RESUME)
						state <= ST_WAIT;
					else
						state <= ST_FINISH;
				end
			end
		end
		ST_WAIT: begin
			// Status read of the target: poll bit and alternating bit
			if (!cyc_busy && !cyc_start) begin
				cyc_start <= 1'b1;
				cyc_write <= 1'b0;
				cyc_addr <= op_addr; // R20
				state <= ST_POLL;
			end
		end
		ST_POLL: begin
			if (cyc_done) begin
				have_prev <= 1'b1;
				prev_read <= cyc_rdata;
				// Done when pin shows ready and the alternating bit has stopped
				if (have_prev && rb_sync &&
					cyc_rdata[`FCC_ALT_BIT] == prev_read[`FCC_ALT_BIT]) begin // R10
					// Program must read back bit 7 of its data; erase and resume must read bit 7 as one
					if (op == `FCC_OP_PROG)
						op_error_out <= cyc_rdata[`FCC_POLL_BIT] != op_data[`FCC_POLL_BIT]; // R14
					else
						op_error_out <= ~cyc_rdata[`FCC_POLL_BIT]; // R14
					state <= ST_FINISH; // R11
				end else
					state <= ST_WAIT;
			end
		end
		ST_FINISH: begin
			op_done_out <= 1'b1;
			op_ready_out <= 1'b1;
			state <= ST_IDLE;
		end
		default: state <= ST_RESET;
		endcase
	end
end

endmodule

// ---- sim/fcc_controller_chk.sv ----
/* Port checker for the flash command controller.
 * Assumes one clock domain and the bus cycle timing set in fcc_map.vh. */
`timescale 1ns/1ns
module fcc_controller_chk #(
	parameter ADDR_W = 20
) (
	input wire clock_in,
	input wire reset_n_in,
	input wire op_valid_in,
	input wire [2:0] op_code_in,
	input wire [ADDR_W-1:0] op_addr_in,
	input wire [15:0] op_data_in,
	input wire byte_mode_in,
	input wire [15:0] data_lines_in,
	input wire operation_done_pin_in,
	input wire op_ready_out,
	input wire op_done_out,
	input wire op_error_out,
	input wire [15:0] rd_data_out,
	input wire [ADDR_W-1:0] flash_addr_out,
	input wire [15:0] data_lines_out,
	input wire data_lines_oe_n_out,
	input wire chip_sel_n_out,
	input wire write_n_out,
	input wire read_n_out,
	input wire byte_n_out,
	input wire flash_reset_n_out
);
	reg [6:0] rst_cnt;
	reg [4:0] stb_len;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	////////////////////////////////////////////////////////////////
	// Cycles since reset release and length of the current strobe
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_cnt <= 7'h00;
			stb_len <= 5'h00;
		end else begin
			rst_cnt <= (rst_cnt == 7'h7f) ? rst_cnt : rst_cnt + 7'h01;
			stb_len <= (!write_n_out || !read_n_out) ? stb_len + 5'h01 : 5'h00;
		end
	end
	////////////////////////////////////////////////////////////////
	strobe_excl_a: assert property (write_n_out || read_n_out)
		else $error("read and write strobes low together");
	drive_clash_a: assert property (!data_lines_oe_n_out |-> read_n_out)
		else $error("host drives data lines during a read strobe");
	strobe_sel_a: assert property ((!write_n_out || !read_n_out) |-> !chip_sel_n_out)
		else $error("strobe without chip select");
	strobe_len_a: assert property ($rose(write_n_out) || $rose(read_n_out) |-> stb_len == 5'd13)
		else $error("strobe length not 13 cycles");
	bus_gap_a: assert property ($rose(write_n_out) |-> (write_n_out && read_n_out)[*4])
		else $error("strobe gap too short");
	write_hold_a: assert property (!write_n_out && !$past(write_n_out) |->
		$stable(data_lines_out) && $stable(flash_addr_out) && !data_lines_oe_n_out)
		else $error("write address or data moved under strobe");
	done_pulse_a: assert property (op_done_out |=> !op_done_out)
		else $error("done longer than one cycle");
	done_ready_a: assert property (op_done_out |-> op_ready_out)
		else $error("done without ready");
	take_busy_a: assert property (op_valid_in && op_ready_out |=> !op_ready_out)
		else $error("ready stayed high after take");
	reset_hold_a: assert property ($rose(flash_reset_n_out) |-> rst_cnt >= 7'd62 && op_ready_out)
		else $error("device reset released early");
	width_pin_a: assert property (flash_reset_n_out && $stable(byte_mode_in) &&
		byte_mode_in == $past(byte_mode_in, 2) |-> byte_n_out == !byte_mode_in)
		else $error("width pin does not follow byte mode");
	cover property (op_done_out && op_error_out);
	cover property (op_done_out && byte_mode_in);
	cover property ($fell(write_n_out));
endmodule
bind fcc_controller fcc_controller_chk #(.ADDR_W(ADDR_W)) fcc_controller_chk_i (
	.clock_in(clock_in), .reset_n_in(reset_n_in), .op_valid_in(op_valid_in),
	.op_code_in(op_code_in), .op_addr_in(op_addr_in), .op_data_in(op_data_in),
	.byte_mode_in(byte_mode_in), .data_lines_in(data_lines_in),
	.operation_done_pin_in(operation_done_pin_in), .op_ready_out(op_ready_out),
	.op_done_out(op_done_out), .op_error_out(op_error_out), .rd_data_out(rd_data_out),
	.flash_addr_out(flash_addr_out), .data_lines_out(data_lines_out),
	.data_lines_oe_n_out(data_lines_oe_n_out), .chip_sel_n_out(chip_sel_n_out),
	.write_n_out(write_n_out), .read_n_out(read_n_out), .byte_n_out(byte_n_out),
	.flash_reset_n_out(flash_reset_n_out));

// ---- sim/fcc_flash_model.sv ----
/* Behavioural flash device: command decoder, 256-word array, 4 sectors.
 * Assumes strobes from the controller; no clock, own time base of 10 ns. */
`timescale 1ns/1ns
module fcc_flash_model #(
	parameter BUSY_T = 200,
	parameter PROT_SEC = 2'h3
) (
	input wire [19:0] addr_in,
	input wire [15:0] data_in,
	input wire chip_sel_n_in,
	input wire write_n_in,
	input wire read_n_in,
	input wire byte_n_in,
	input wire reset_n_in,
	input wire low_supply_in,
	output reg [15:0] data_out,
	output wire drive_out,
	output wire ready_out
);
	reg [15:0] mem [0:255];
	reg [15:0] last, target;
	reg [2:0] step;
	reg byp, ers, susp, alt;
	integer left, i;
	wire [19:0] wa = byte_n_in ? addr_in : addr_in >> 1;
	wire [7:0] d = data_in[7:0];
	assign drive_out = !chip_sel_n_in && !read_n_in;
	assign ready_out = (left == 0) || susp;
	initial begin
		for (i = 0; i < 256; i = i + 1) mem[i] = 16'hffff;
		{step, byp, ers, susp, alt, left, last, target} = 0;
		forever begin
			#10;
			if (left > 0 && !susp) left = left - 1;
		end
	end
	////////////////////////////////////////////////////////////////
	// Released lines show the inverse of the last value, never a stale copy
	always @* begin
		if (!drive_out) data_out = ~last;
		else if (!ready_out) data_out = {8'h00, ~target[7], alt, 6'h00};
		else if (!byte_n_in) data_out = {~last[15:8], addr_in[0] ? mem[wa[7:0]][15:8] :
			mem[wa[7:0]][7:0]};
		else data_out = mem[wa[7:0]];
	end
	always @(posedge read_n_in) begin
		last <= data_out;
		if (!ready_out) alt <= ~alt;
	end
	always @(negedge reset_n_in) {step, byp, susp, left} = 0;
	////////////////////////////////////////////////////////////////
	// Command decoder; sector is word address bits 7:6, a scaled map
	// A write ends when chip select or write strobe rises, whichever is first; both
	// rise in one time step here, so the end of their overlap is the only safe edge
	wire wr_act = !chip_sel_n_in && !write_n_in;
	always @(negedge wr_act) if (reset_n_in && !low_supply_in) begin
		if (!ready_out) begin
			if (d == 8'hb0 && target == 16'hffff) susp <= 1'b1;
		end else if (step == 3'h0) begin
			if (susp && d == 8'h30) susp <= 1'b0;
			else if (byp && d == 8'h90) byp <= 1'b0;
			else if (byp && d == 8'ha0) step <= 3'h3;
			else step <= (wa[10:0] == 11'h555 && d == 8'haa) ? 3'h1 : 3'h0;
		end else if (step == 3'h1) begin
			step <= (wa[10:0] == 11'h2aa && d == 8'h55) ? 3'h2 : 3'h0;
		end else if (step == 3'h2) begin
			step <= (wa[10:0] == 11'h555 && d == 8'ha0) ? 3'h3 : 3'h0;
			if (wa[10:0] == 11'h555 && d == 8'h80) ers <= 1'b1;
			if (wa[10:0] == 11'h555 && d == 8'h20) byp <= 1'b1;
			if (ers && (d == 8'h30 || (d == 8'h10 && wa[10:0] == 11'h555))) begin
				ers <= 1'b0;
				target <= 16'hffff;
				left <= 2 * BUSY_T;
				for (i = 0; i < 256; i = i + 1)
					if (i[7:6] != PROT_SEC && (d == 8'h10 || i[7:6] == wa[7:6]))
						mem[i] <= 16'hffff;
			end
		end else begin
			step <= 3'h0;
			target <= data_in;
			left <= (wa[7:6] == PROT_SEC) ? 5 : BUSY_T;
			if (wa[7:6] != PROT_SEC) mem[wa[7:0]] <= mem[wa[7:0]] & data_in;
		end
	end
endmodule

// ---- sim/fcc_controller_test.sv ----
/* Self-checking bench for the flash command controller with a flash model.
 * Assumes the opcodes of fcc_map.vh and a one-cycle valid taken while ready is high. */
`timescale 1ns/1ns
`include "fcc_map.vh"
module fcc_controller_test;
	reg clock_in = 0, reset_n_in = 0, op_valid = 0, byte_mode = 0, low_supply = 0;
	reg [2:0] op_code = 0;
	reg [19:0] op_addr = 0;
	reg [15:0] op_data = 0;
	wire ready, done, err, oe_n, cs_n, we_n, re_n, byte_n, frst_n, drive, rdy_pin;
	wire [15:0] rd, dl_out, dev_data;
	wire [19:0] faddr;
	wire [15:0] dl_in = !oe_n ? dl_out : dev_data;
	integer fail_count = 0, n_compared = 0, cycles = 0;
	fcc_controller fcc_controller_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.op_valid_in(op_valid), .op_code_in(op_code), .op_addr_in(op_addr),
		.op_data_in(op_data), .byte_mode_in(byte_mode), .data_lines_in(dl_in),
		.operation_done_pin_in(rdy_pin), .op_ready_out(ready), .op_done_out(done),
		.op_error_out(err), .rd_data_out(rd), .flash_addr_out(faddr),
		.data_lines_out(dl_out), .data_lines_oe_n_out(oe_n), .chip_sel_n_out(cs_n),
		.write_n_out(we_n), .read_n_out(re_n), .byte_n_out(byte_n),
		.flash_reset_n_out(frst_n));
	fcc_flash_model fcc_flash_model_i (.addr_in(faddr), .data_in(dl_in), .chip_sel_n_in(cs_n),
		.write_n_in(we_n), .read_n_in(re_n), .byte_n_in(byte_n), .reset_n_in(frst_n),
		.low_supply_in(low_supply), .data_out(dev_data), .drive_out(drive),
		.ready_out(rdy_pin));
	initial forever #4 clock_in = ~clock_in;
	////////////////////////////////////////////////////////////////
	// Hang guard: the whole run needs well under 30000 cycles
	always @(posedge clock_in) begin
		cycles = cycles + 1;
		if (cycles == 60000) begin
			fail_count = fail_count + 1;
			summarize;
		end
	end
	task summarize;
		begin
			$display("compared %0d, mismatches %0d", n_compared, fail_count);
			if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
			else $display("Testbench failed");
			$finish;
		end
	endtask
	task check_data(input [8*10:1] name, input [15:0] exp, input [15:0] got);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("ERROR %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task check_flag(input [8*10:1] name, input exp, input got);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("ERROR %0s expected %b seen %b", name, exp, got);
			end
		end
	endtask
	// Issue one operation and wait, bounded, for its done pulse
	task run_op(input [2:0] c, input [19:0] a, input [15:0] d);
		integer n;
		begin
			n = 0;
			while (ready !== 1'b1 && n < 2000) begin
				@(posedge clock_in);
				#1 n = n + 1;
			end
			@(posedge clock_in);
			{op_code, op_addr, op_data, op_valid} <= {c, a, d, 1'b1};
			@(posedge clock_in);
			op_valid <= 1'b0;
			n = 0;
			while (done !== 1'b1 && n < 9000) begin
				@(posedge clock_in);
				#1 n = n + 1;
			end
			check_flag("done", 1'b1, done);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clock_in);
		reset_n_in <= 1'b1;
		run_op(`FCC_OP_READ, 20'h00010, 16'h0000);
		check_data("erased", 16'hffff, rd);
		run_op(`FCC_OP_PROG, 20'h00010, 16'h1234);
		check_flag("prog err", 1'b0, err);
		run_op(`FCC_OP_READ, 20'h00010, 16'h0000);
		check_data("prog rd", 16'h1234, rd);
		run_op(`FCC_OP_PROG, 20'h00050, 16'h00a5);
		run_op(`FCC_OP_SECT, 20'h00010, 16'h0000);
		check_flag("sect err", 1'b0, err);
		run_op(`FCC_OP_READ, 20'h00010, 16'h0000);
		check_data("sect rd", 16'hffff, rd);
		run_op(`FCC_OP_READ, 20'h00050, 16'h0000);
		check_data("other rd", 16'h00a5, rd);
		// Address pins left still for a long while: a sleeping device must still answer
		repeat (300) @(posedge clock_in);
		run_op(`FCC_OP_READ, 20'h00050, 16'h0000);
		check_data("sleep rd", 16'h00a5, rd);
		$display("test program and sector erase done");
		run_op(`FCC_OP_BYP_ON, 20'h00000, 16'h0000);
		run_op(`FCC_OP_PROG, 20'h00020, 16'h5a3c);
		check_flag("byp err", 1'b0, err);
		run_op(`FCC_OP_BYP_OFF, 20'h00000, 16'h0000);
		run_op(`FCC_OP_READ, 20'h00020, 16'h0000);
		check_data("byp rd", 16'h5a3c, rd);
		@(posedge clock_in) byte_mode <= 1'b1;
		run_op(`FCC_OP_READ, 20'h00041, 16'h0000);
		check_data("byte hi", 16'h005a, rd);
		run_op(`FCC_OP_READ, 20'h00040, 16'h0000);
		check_data("byte lo", 16'h003c, rd);
		@(posedge clock_in) byte_mode <= 1'b0;
		$display("test bypass and byte width done");
		run_op(`FCC_OP_PROG, 20'h000c4, 16'h0000);
		check_flag("prot err", 1'b1, err);
		run_op(`FCC_OP_READ, 20'h000c4, 16'h0000);
		check_data("prot rd", 16'hffff, rd);
		@(posedge clock_in) low_supply <= 1'b1;
		run_op(`FCC_OP_PROG, 20'h00030, 16'h0000);
		check_flag("low err", 1'b1, err);
		@(posedge clock_in) low_supply <= 1'b0;
		run_op(`FCC_OP_READ, 20'h00030, 16'h0000);
		check_data("low rd", 16'hffff, rd);
		$display("test write refusal done");
		run_op(`FCC_OP_SUSP, 20'h00000, 16'h0000);
		run_op(`FCC_OP_RESUME, 20'h00010, 16'h0000);
		check_flag("resume err", 1'b0, err);
		run_op(`FCC_OP_CHIP, 20'h00000, 16'h0000);
		check_flag("chip err", 1'b0, err);
		run_op(`FCC_OP_READ, 20'h00050, 16'h0000);
		check_data("chip rd", 16'hffff, rd);
		run_op(`FCC_OP_READ, 20'h00020, 16'h0000);
		check_data("chip rd2", 16'hffff, rd);
		$display("test suspend and chip erase done");
		summarize;
	end
endmodule
